// >>> hw/exb_consts.svh
// Constants for the exception binding and pin zero control block
// Functional notes
// - Channel X action code, bits 3:0, reset zero
// - X link bit 7 fires X action
// - X event select bits 4:0, reset 0x12
// - Channel Y action code, bits 3:0, reset zero
// - Y link bit 7 fires Y action
// - Y event select bits 4:0, reset 0x12
// - Pin zero direction bit 7, one=input
// - Output mode: select field picks driven signal
// - Input mode: active edge fires coded action
// - Input select above 0x0F fires nothing
// - Polarity picks active edge, resets one
`ifndef EXB_CONSTS_SVH
`define EXB_CONSTS_SVH
`define EXB_IDX_X_ACTION   8'h1C
`define EXB_IDX_X_EVENT    8'h1D
`define EXB_IDX_Y_ACTION   8'h1E
`define EXB_IDX_Y_EVENT    8'h1F
`define EXB_IDX_PIN0_CFG   8'h20
`define EXB_IDX_PIN0_POL   8'h26
`define EXB_IDX_STATUS     8'h30
`define EXB_RST_ACTION     4'h0
`define EXB_RST_EVENT      5'h12
`define EXB_RST_PIN0_CFG   8'h00
`define EXB_RST_POL        1'b1
`define EXB_BIT_LINK_ON    7
`define EXB_BIT_DIRECTION  7
`define EXB_MAX_PIN_CODE   7'h0F
`endif

// >>> hw/exb_pkg.sv
// Types shared by the exception binding block
package exb_pkg;
  typedef logic [3:0] exb_code_type;   // Action code
  typedef logic [4:0] exb_event_type;  // Event number
  typedef logic [23:0] exb_flags_type; // Exception event pulses
  typedef logic [127:0] exb_sigs_type; // Signals selectable onto pin
endpackage

// >>> hw/exb_req_if.sv
// Request carrier between the binding top and its channel module
`timescale 1ns/100ps
`default_nettype none
interface exb_req_if;
  import exb_pkg::*;
  logic          link_on;  // Binding enabled
  exb_event_type ev_sel;   // Selected exception
  exb_code_type  code;     // Action to fire
  logic          fire;     // One-cycle request
  exb_code_type  fire_code;// Code with the request
  modport chan (input link_on, ev_sel, code, output fire, fire_code);
  modport top  (output link_on, ev_sel, code, input fire, fire_code);
endinterface
`default_nettype wire

// >>> hw/exb_channel.sv
// One exception binding channel: event match to one request pulse
`timescale 1ns/100ps
`default_nettype none
module exb_channel
  import exb_pkg::*;
(
  input  wire logic          i_clk_sys, // System clock
  input  wire logic          i_rst_b,   // Async reset, low
  input  wire exb_pkg::exb_flags_type i_exc, // Exception pulses
  exb_req_if.chan            req        // Binding settings and request
);
  logic fire_q;           // Request pulse
  exb_code_type code_q;   // Registered code
  logic hit;              // Selected exception seen

  // Numbers past 23 never match
  assign hit = (req.ev_sel < 5'd24) && i_exc[req.ev_sel];

  // One pulse per event cycle while linked
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      fire_q <= 1'b0;
      code_q <= 4'h0;
    end
    else
    begin
      fire_q <= req.link_on && hit;
      code_q <= req.code;
    end
  end

  assign req.fire      = fire_q;
  assign req.fire_code = code_q;
endmodule
`default_nettype wire

// >>> hw/exb_top.sv
// Exception binding and pin zero control with APB register access
`include "exb_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module exb_top
(
  input  wire logic        i_clk_sys,     // 50 MHz system clock
  input  wire logic        i_rst_b,       // Async reset, low
  input  wire logic        i_psel,        // APB select
  input  wire logic        i_penable,     // APB enable
  input  wire logic        i_pwrite,      // APB write
  input  wire logic [11:0] i_paddr,       // APB byte address
  input  wire logic [31:0] i_pwdata,      // APB write data
  output logic [31:0]      o_prdata,      // APB read data
  output logic             o_pready,      // APB ready
  output logic             o_pslverr,     // APB error
  input  wire exb_pkg::exb_flags_type i_exc, // Exception pulses
  input  wire exb_pkg::exb_sigs_type  i_sigs, // Output mux sources
  input  wire logic        i_pin_zero,    // Pin zero level in
  output logic             o_pin_zero,    // Pin zero level out
  output logic             o_pin_zero_oe_b, // Low while driving
  output logic             o_x_req,       // Channel X request
  output logic [3:0]       o_x_code,      // Channel X action
  output logic             o_y_req,       // Channel Y request
  output logic [3:0]       o_y_code,      // Channel Y action
  output logic             o_pin_req,     // Pin edge request
  output logic [3:0]       o_pin_code     // Pin action
);
  import exb_pkg::*;

  // Byte address of a register index, one word per register
  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction

  exb_code_type  x_action_code_q;   // X action
  logic          x_link_on_q;       // X enable
  exb_event_type x_event_select_q;  // X event
  exb_code_type  y_action_code_q;   // Y action
  logic          y_link_on_q;       // Y enable
  exb_event_type y_event_select_q;  // Y event
  logic          pin_zero_direction_q; // 1 = input
  logic [6:0]    pin_zero_select_q; // Mux or action select
  logic          pin_zero_pol_q;    // 1 = rising edge active
  logic          sync1_q;           // Pin sync stage 1
  logic          sync2_q;           // Pin sync stage 2
  logic          last_q;            // Previous synced level
  logic          pin_req_q;         // Pin request pulse
  exb_code_type  pin_code_q;        // Pin request code
  logic          pin_out_q;         // Registered output level
  logic [2:0]    seen_q;            // Sticky request seen flags
  logic          wr_en;             // APB write strobe
  logic          rd_en;             // APB read strobe
  logic          addr_ok;           // Address mapped
  logic          pin_edge;          // Active edge seen
  logic [31:0]   rd_data;           // Read mux

  exb_req_if x_if ();
  exb_req_if y_if ();

  // APB access phase strobes; zero wait states
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && i_penable && !i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok;

  // Address decode
  always_comb
  begin
    unique case (i_paddr)
      reg_addr(`EXB_IDX_X_ACTION),
      reg_addr(`EXB_IDX_X_EVENT),
      reg_addr(`EXB_IDX_Y_ACTION),
      reg_addr(`EXB_IDX_Y_EVENT),
      reg_addr(`EXB_IDX_PIN0_CFG),
      reg_addr(`EXB_IDX_PIN0_POL),
      reg_addr(`EXB_IDX_STATUS): addr_ok = 1'b1;
      default:                   addr_ok = 1'b0;
    endcase
  end

  // Channel X settings
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      x_action_code_q  <= `EXB_RST_ACTION;
      x_link_on_q      <= 1'b0;
      x_event_select_q <= `EXB_RST_EVENT;
    end
    else if (wr_en && i_paddr == reg_addr(`EXB_IDX_X_ACTION))
      x_action_code_q <= i_pwdata[3:0];
    else if (wr_en && i_paddr == reg_addr(`EXB_IDX_X_EVENT))
    begin
      x_link_on_q      <= i_pwdata[`EXB_BIT_LINK_ON];
      x_event_select_q <= i_pwdata[4:0];
    end
  end

  // Channel Y settings
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      y_action_code_q  <= `EXB_RST_ACTION;
      y_link_on_q      <= 1'b0;
      y_event_select_q <= `EXB_RST_EVENT;
    end
    else if (wr_en && i_paddr == reg_addr(`EXB_IDX_Y_ACTION))
      y_action_code_q <= i_pwdata[3:0];
    else if (wr_en && i_paddr == reg_addr(`EXB_IDX_Y_EVENT))
    begin
      y_link_on_q      <= i_pwdata[`EXB_BIT_LINK_ON];
      y_event_select_q <= i_pwdata[4:0];
    end
  end

  // Pin zero configuration and polarity
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pin_zero_direction_q <= 1'b0;
      pin_zero_select_q    <= 7'(`EXB_RST_PIN0_CFG);
      pin_zero_pol_q       <= `EXB_RST_POL;
    end
    else if (wr_en && i_paddr == reg_addr(`EXB_IDX_PIN0_CFG))
    begin
      pin_zero_direction_q <= i_pwdata[`EXB_BIT_DIRECTION];
      pin_zero_select_q    <= i_pwdata[6:0];
    end
    else if (wr_en && i_paddr == reg_addr(`EXB_IDX_PIN0_POL))
      pin_zero_pol_q <= i_pwdata[0];
  end

  // Binding channels
  assign x_if.link_on = x_link_on_q;
  assign x_if.ev_sel  = x_event_select_q;
  assign x_if.code    = x_action_code_q;
  assign y_if.link_on = y_link_on_q;
  assign y_if.ev_sel  = y_event_select_q;
  assign y_if.code    = y_action_code_q;

  exb_channel u_chan_x
  (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_exc     (i_exc),
    .req       (x_if.chan)
  );

  exb_channel u_chan_y
  (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_exc     (i_exc),
    .req       (y_if.chan)
  );

  // Pin sync; stage 1 is read only by stage 2
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q  <= 1'b0;
    end
    else
    begin
      sync1_q <= i_pin_zero;
      sync2_q <= sync1_q;
      last_q  <= sync2_q;
    end
  end

  // Active edge per polarity
  assign pin_edge = pin_zero_pol_q ? (sync2_q && !last_q)
                                   : (!sync2_q && last_q);

  // Pin edge request; only in input mode with a code up to 0x0F
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pin_req_q  <= 1'b0;
      pin_code_q <= 4'h0;
    end
    else
    begin
      pin_req_q <= pin_zero_direction_q && pin_edge
                   && (pin_zero_select_q <= `EXB_MAX_PIN_CODE);
      pin_code_q <= pin_zero_select_q[3:0];
    end
  end

  // Output mux, registered; driven only in output mode
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      pin_out_q <= 1'b0;
    else
      pin_out_q <= i_sigs[pin_zero_select_q];
  end

  assign o_pin_zero      = pin_out_q;
  assign o_pin_zero_oe_b = pin_zero_direction_q;

  // Sticky seen flags; a new request wins over the clear
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      seen_q <= 3'h0;
    else
    begin
      if (wr_en && i_paddr == reg_addr(`EXB_IDX_STATUS))
        seen_q <= seen_q & ~i_pwdata[2:0];
      if (x_if.fire)
        seen_q[0] <= 1'b1;
      if (y_if.fire)
        seen_q[1] <= 1'b1;
      if (pin_req_q)
        seen_q[2] <= 1'b1;
    end
  end

  // Read mux; reserved bits read zero
  always_comb
  begin
    rd_data = 32'h0;
    unique case (i_paddr)
      reg_addr(`EXB_IDX_X_ACTION): rd_data[3:0] = x_action_code_q;
      reg_addr(`EXB_IDX_X_EVENT):
        rd_data[7:0] = {x_link_on_q, 2'b00, x_event_select_q};
      reg_addr(`EXB_IDX_Y_ACTION): rd_data[3:0] = y_action_code_q;
      reg_addr(`EXB_IDX_Y_EVENT):
        rd_data[7:0] = {y_link_on_q, 2'b00, y_event_select_q};
      reg_addr(`EXB_IDX_PIN0_CFG):
        rd_data[7:0] = {pin_zero_direction_q, pin_zero_select_q};
      reg_addr(`EXB_IDX_PIN0_POL): rd_data[0] = pin_zero_pol_q;
      reg_addr(`EXB_IDX_STATUS):
        rd_data[4:0] = {sync2_q, pin_zero_direction_q, seen_q};
      default: rd_data = 32'h0;
    endcase
  end

  // Read data register, loaded in the setup phase of a read
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_prdata <= 32'h0;
    else if (i_psel && !i_penable && !i_pwrite)
      o_prdata <= rd_data;
  end

  assign o_x_req    = x_if.fire;
  assign o_x_code   = x_if.fire_code;
  assign o_y_req    = y_if.fire;
  assign o_y_code   = y_if.fire_code;
  assign o_pin_req  = pin_req_q;
  assign o_pin_code = pin_code_q;
endmodule
`default_nettype wire

// >>> dv/exb_top_props.sv
// Port checker for the binding and pin zero block
`timescale 1ns/100ps
`default_nettype none
module exb_top_props
  import exb_pkg::*;
(
  input wire logic           i_clk_sys,       // Clock
  input wire logic           i_rst_b,         // Reset, low
  input wire logic           i_psel,          // APB select
  input wire logic           i_penable,       // APB enable
  input wire exb_flags_type  i_exc,           // Exception pulses
  input wire exb_sigs_type   i_sigs,          // Mux sources
  input wire logic           i_pin_zero,      // Pin level in
  input wire logic           o_pin_zero,      // Pin level out
  input wire logic           o_pin_zero_oe_b, // Low while driving
  input wire logic           o_pslverr,       // APB error
  input wire logic           o_x_req,         // X request
  input wire logic           o_y_req,         // Y request
  input wire logic           o_pin_req        // Pin request
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // Pin moved within the sync and edge window; spacing kept wide
  sequence s_pin_moved;
    $past(i_pin_zero, 1) != $past(i_pin_zero, 6);
  endsequence
  property p_x_cause; o_x_req |-> $past(i_exc) != '0; endproperty
  property p_y_cause; o_y_req |-> $past(i_exc) != '0; endproperty
  // Direction as it stood when the edge was taken, one cycle back
  property p_pin_dir; o_pin_req |-> $past(o_pin_zero_oe_b); endproperty
  property p_pin_cause; o_pin_req |-> s_pin_moved; endproperty
  property p_pin_pulse; o_pin_req |=> !o_pin_req; endproperty
  property p_out_low;
    (!o_pin_zero_oe_b && $past(i_sigs) == '0) |-> !o_pin_zero;
  endproperty
  property p_out_high;
    (!o_pin_zero_oe_b && $past(i_sigs) == '1) |-> o_pin_zero;
  endproperty
  property p_err_access; o_pslverr |-> i_psel && i_penable; endproperty
  a_x_cause: assert property (p_x_cause)
    else $error("x request without exception");
  a_y_cause: assert property (p_y_cause)
    else $error("y request without exception");
  a_pin_dir: assert property (p_pin_dir)
    else $error("pin request in output mode");
  a_pin_cause: assert property (p_pin_cause)
    else $error("pin request without pin change");
  a_pin_pulse: assert property (p_pin_pulse)
    else $error("pin request longer than one cycle");
  a_out_low: assert property (p_out_low)
    else $error("pin high with all sources low");
  a_out_high: assert property (p_out_high)
    else $error("pin low with all sources high");
  a_err_access: assert property (p_err_access)
    else $error("error outside access phase");
endmodule
bind exb_top exb_top_props u_props (.i_clk_sys, .i_rst_b, .i_psel,
  .i_penable, .i_exc, .i_sigs, .i_pin_zero, .o_pin_zero,
  .o_pin_zero_oe_b, .o_pslverr, .o_x_req, .o_y_req, .o_pin_req);
`default_nettype wire

// >>> dv/exb_pin_host.sv
// Host controller model wired to pin zero
`timescale 1ns/100ps
`default_nettype none
module exb_pin_host
(
  input  wire logic i_clk_sys,  // Clock
  input  wire logic i_dev_lvl,  // Level from device
  input  wire logic i_dev_oe_b, // Low while device drives
  output var  logic o_pin       // Resolved wire level
);
  logic lvl_q = 1'b0; // Host drive level
  // Host only drives while the device listens, so no fight
  assign o_pin = i_dev_oe_b ? lvl_q : i_dev_lvl;
  // Level moves just after an edge
  task automatic drive(input logic v);
    @(posedge i_clk_sys);
    lvl_q <= v;
  endtask
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the binding and pin zero block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import exb_pkg::*;
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0; // Controls
  logic [11:0] paddr = '0;                  // APB address
  logic [31:0] pwdata = '0, prdata, r;      // APB data
  logic pready, pslverr, err, pin_in, pin_out, oe_b; // Status
  logic x_req, y_req, p_req;                // Requests
  logic [3:0] x_code, y_code, p_code;       // Codes
  exb_flags_type exc = '0;                  // Exceptions
  exb_sigs_type sigs = '0;                  // Mux sources
  logic [7:0] mdl [6], cfg;                 // Register model
  logic sx = 0, sy = 0;                     // Modelled seen flags
  int failures = 0, checked = 0, seed = 96, cyc = 0, npulse;
  localparam logic [11:0] ADR [6] = '{'h70, 'h74, 'h78, 'h7C, 'h80, 'h98};
  localparam logic [7:0] MSK [6] = '{'h0F, 'h9F, 'h0F, 'h9F, 'hFF, 'h01};
  localparam logic [7:0] RST [6] = '{'h00, 'h12, 'h00, 'h12, 'h00, 'h01};
  exb_top DUT (.i_clk_sys(clk), .i_rst_b(rst_b), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_exc(exc), .i_sigs(sigs), .i_pin_zero(pin_in), .o_pin_zero(pin_out),
    .o_pin_zero_oe_b(oe_b), .o_x_req(x_req), .o_x_code(x_code),
    .o_y_req(y_req), .o_y_code(y_code), .o_pin_req(p_req),
    .o_pin_code(p_code));
  exb_pin_host host (.i_clk_sys(clk), .i_dev_lvl(pin_out),
    .i_dev_oe_b(oe_b), .o_pin(pin_in));
  // 50 MHz clock
  initial
  begin
    forever #10 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      failures++;
      summarize();
    end
  end
  // Pin requests counted off the edge
  always @(negedge clk)
  begin
    if (p_req === 1'b1)
    begin
      npulse++;
      chk(p_code, mdl[4][3:0]);
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // One APB transfer, held until ready at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    err = pslverr;
    {psel, pen} <= 2'b00;
  endtask
  task automatic wr(input int i, input logic [31:0] v);
    apb(1'b1, ADR[i], v);
    mdl[i] = v[7:0] & MSK[i];
  endtask
  task automatic rd(input int i);
    apb(1'b0, ADR[i], '0);
    chk(r, {24'h0, mdl[i]});
  endtask
  // Expected request for one channel setting
  function automatic logic hit(input logic [7:0] ev);
    return ev[7] && ev[4:0] < 5'd24 && exc[ev[4:0]];
  endfunction
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    for (int i = 0; i < 6; i++)
      mdl[i] = RST[i];
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 18; i++)
    begin
      if (i >= 6)
        wr(i % 6, $random(seed));
      rd(i % 6);
    end
    // Unmapped place refuses both ways
    apb(1'b1, 12'h100, '1);
    chk(err, 1);
    chk(pready, 1);
    apb(1'b0, 12'h100, '0);
    chk(r, 0);
    chk(err, 1);
    // Random bindings against random exception traffic
    for (int k = 0; k < 64; k++)
    begin
      // Quiet events while bindings move, so the seen model stays exact
      if (k % 8 == 0)
      begin
        exc <= '0;
        for (int i = 0; i < 4; i++)
          wr(i, $random(seed));
      end
      @(posedge clk);
      exc <= exb_flags_type'($random(seed));
      @(posedge clk);
      #1;
      sx |= hit(mdl[1]);
      sy |= hit(mdl[3]);
      chk(x_req, hit(mdl[1]));
      chk(y_req, hit(mdl[3]));
      if (x_req === 1'b1)
        chk(x_code, mdl[0][3:0]);
      if (y_req === 1'b1)
        chk(y_code, mdl[2][3:0]);
    end
    exc <= '0;
    // Sticky seen flags, then write one to clear; pin idles low here
    apb(1'b0, 12'hC0, '0);
    chk(r, {27'h0, 1'b0, mdl[4][7], 1'b0, sy, sx});
    apb(1'b1, 12'hC0, 32'h3);
    apb(1'b0, 12'hC0, '0);
    chk(r, {27'h0, 1'b0, mdl[4][7], 3'h0});
    // Output mode: select picks the driven source
    for (int k = 0; k < 12; k++)
    begin
      wr(4, $random(seed) & 32'h7F);
      @(posedge clk);
      sigs <= (k < 2) ? {128{k[0]}} :
        {$random(seed), $random(seed), $random(seed), $random(seed)};
      repeat (2) @(posedge clk);
      #1;
      chk({oe_b, pin_out}, {1'b0, sigs[mdl[4][6:0]]});
    end
    // Input mode, both polarities, then an idle code above 0x0F
    for (int k = 0; k < 4; k++)
    begin
      cfg = 8'(32'h80 | ($random(seed) & 32'hF) | ((k == 3) ? 32'h10 : 32'h0));
      wr(4, cfg);
      wr(5, k[0]);
      repeat (10) @(posedge clk);
      npulse = 0;
      for (int t = 0; t < 4; t++)
      begin
        host.drive(~t[0]);
        repeat (10) @(posedge clk);
      end
      chk(npulse, (k == 3) ? 0 : 2);
    end
    summarize();
  end
endmodule
`default_nettype wire
